// >>> verilog/imh_pkg.sv
// Package: register map, field layout, timing and carrier types of the message host port
package imh_pkg;
	// Register indices; byte address on the bus is four times the index
	localparam logic [2:0] REG_STATUS   = 3'h0;
	localparam logic [2:0] REG_IDENTITY = 3'h1;
	localparam logic [2:0] REG_ATTRIB   = 3'h2;
	localparam logic [2:0] REG_IRQ_EN   = 3'h3;
	localparam logic [2:0] REG_MSG_PORT = 3'h4;
	localparam logic [2:0] REG_ERR_PORT = 3'h5;
	localparam logic [2:0] REG_TERMINATE = 3'h7;

	// Status bit positions
	localparam int ST_TX_ROOM  = 0;
	localparam int ST_RX_MSG   = 1;
	localparam int ST_TX_FAIL  = 2;
	localparam int ST_SETUP    = 7;

	// Interrupt enable bit positions
	localparam int IE_TX_ROOM  = 0;
	localparam int IE_RX_MSG   = 1;
	localparam int IE_TX_FAIL  = 2;

	// Attribute register: only bits 6..4 are stored, the rest read as zero
	localparam logic [7:0] ATTRIB_MASK  = 8'h70;
	localparam logic [7:0] ATTRIB_RESET = 8'h00;

	// Error flags folded into the request identifier byte of the error packet
	localparam int ERR_RETRY_BIT   = 4;
	localparam int ERR_BUSERR_BIT  = 5;
	localparam int ERR_TIMEOUT_BIT = 6;
	localparam logic [7:0] REQ_ID_MASK = 8'h0F;

	// Packet constants
	localparam logic [7:0] PKT_BYTE_COUNT = 8'h04;
	localparam logic [7:0] MSG_TYPE_INT   = 8'h00;
	localparam logic [1:0] WIDTH_32       = 2'h3;
	localparam logic [1:0] XFER_ONE       = 2'h1;
	localparam logic [7:0] RESET_BYTE     = 8'h00;

	// End-of-interrupt blanking time and its cycle count at the 50 ns clock
	localparam int EOI_NS  = 200;
	localparam int CLK_NS  = 50;
	localparam int EOI_CYC = (EOI_NS / CLK_NS) < 1 ? 1 : (EOI_NS / CLK_NS);

	// Outgoing message-space write
	typedef struct packed {
		logic [31:0] req_word;   // Request phase: dest in [7:0], source in [15:8]
		logic [31:0] reply_word; // Reply phase: type in [7:0]
		logic [1:0]  width;      // Always 32-bit
		logic [1:0]  xfers;      // Always one data transfer
	} imh_sbus_req_t;

	// Outcome of an outgoing write, valid with done
	typedef struct packed {
		logic done;
		logic retry_expired;
		logic bus_error;
		logic timeout;
	} imh_sbus_result_t;

	// Incoming message-space write
	typedef struct packed {
		logic       valid;
		logic [7:0] dest;
		logic [7:0] source;
		logic [7:0] msg_type;
		logic       bus_error;
	} imh_sbus_in_t;
endpackage

// >>> verilog/imh_host_port.sv
// Host register interface and message FIFOs of the interrupt message device
// Operation
// - Seven byte registers decoded at indices 0-5,7
// - Status write soft-resets after bus transfer ends
// - Status bit0 set while transmit buffer has room
// - Status bit1 set while receive FIFO nonempty
// - Status bit2 flags failed last transmit attempt
// - Status bit7 set once identity written
// - Stored identity filters incoming message destinations
// - Identity reads return stored value after setup
// - Identity write after setup blanks interrupt 200ns
// - Attributes writable only before setup, always readable
// - Width fields and bit7 read as zero
// - Three interrupt enables, cleared by any reset
// - Interrupt asserted on any enabled status condition
// - Terminate read pops receive FIFO packet
// - Terminate write starts the outgoing send
// - Data port writes transmit, reads receive
// - Receive read sequence: count 4, four bytes
// - Extra data reads never move FIFO pointers
// - Outgoing write is 32-bit, one transfer
// - Request/reply bytes carry ids and type 00H
// - Error packet repeats message with failure flags
// - Error port: count 4, four bytes, write ends
// - No bus activity before setup completes
// - Errored or nonzero-type incoming messages discarded
// - Soft reset drops the interrupt output
//
// Our own choice: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
module imh_host_port
	import imh_pkg::*;
#(
	parameter int RX_DEPTH = 4
)(
	// Clock and reset
	input  wire logic             mclk,
	input  wire logic             resetn,
	// Avalon-MM slave, word addressed
	input  wire logic [2:0]       avs_address,
	input  wire logic             avs_read,
	input  wire logic             avs_write,
	input  wire logic [31:0]      avs_writedata,
	output logic      [31:0]      avs_readdata,
	output logic                  avs_waitrequest,
	// Host interrupt
	output logic                  host_irq_out,
	output logic                  irq_end_pulse,
	// System bus, outgoing messages
	output logic                  sbus_req_valid,
	output imh_sbus_req_t         sbus_req,
	input  wire imh_sbus_result_t sbus_result,
	// System bus, incoming messages
	input  wire imh_sbus_in_t     sbus_in,
	output logic                  sbus_in_accept
);

	localparam int PW = (RX_DEPTH > 1) ? $clog2(RX_DEPTH) : 1;

	if (RX_DEPTH < 1)
	begin : g_chk
		$error("RX_DEPTH must be at least one");
	end

	if (EOI_CYC > 15)
	begin : g_eoi_chk
		$error("EOI_CYC must fit the four-bit blanking counter");
	end

	// Bus slave state
	logic              ack;
	logic              acc_read;
	logic              acc_write;
	logic              soft_rst;
	logic [7:0]        wbyte;
	logic [7:0]        next_rdata;
	// Configuration and status
	logic              setup_complete;
	logic [7:0]        host_id;
	logic [7:0]        attrib;
	logic [2:0]        irq_en;
	logic              tx_failure_flag;
	logic              tx_fifo_has_room;
	logic              rx_fifo_has_msg;
	logic [7:0]        status_byte;
	// Transmit buffer
	logic [7:0]        tx_byte [4];
	logic [2:0]        tx_wr_idx;
	logic              tx_pending;
	// Error packet
	logic [7:0]        err_byte [4];
	logic [2:0]        err_rd_idx;
	// Receive FIFO
	logic [15:0]       rx_mem [RX_DEPTH];
	logic [PW-1:0]     rx_wr_ptr;
	logic [PW-1:0]     rx_rd_ptr;
	logic [PW:0]       rx_count;
	logic [2:0]        rx_rd_idx;
	logic              rx_push;
	logic              rx_pop;
	// End-of-interrupt blanking
	logic [3:0]        eoi_cnt;

	// One wait cycle on every access, so read data comes from a flop.
	// A status write also waits while a bus transfer is in flight.
	assign avs_waitrequest = (avs_read | avs_write)
		& (~ack | (avs_write & avs_address == REG_STATUS & tx_pending & sbus_req_valid));
	assign acc_read  = avs_read & ~avs_waitrequest;
	assign acc_write = avs_write & ~avs_waitrequest;
	assign wbyte     = avs_writedata[7:0];
	assign soft_rst  = acc_write & avs_address == REG_STATUS;

	// Wait-state flop: set in the first cycle, cleared when the access completes
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			ack <= 1'b0;
		else
			ack <= (avs_read | avs_write) & avs_waitrequest;
	end

	// Status composition
	assign tx_fifo_has_room = ~tx_pending;
	assign rx_fifo_has_msg  = (rx_count != '0);
	always_comb
	begin
		status_byte              = 8'h00;
		status_byte[ST_TX_ROOM]  = tx_fifo_has_room;
		status_byte[ST_RX_MSG]   = rx_fifo_has_msg;
		status_byte[ST_TX_FAIL]  = tx_failure_flag;
		status_byte[ST_SETUP]    = setup_complete;
	end

	// Read multiplexer; unmapped index 6 reads zero
	always_comb
	begin
		next_rdata = 8'h00;
		unique case (avs_address)
			REG_STATUS:    next_rdata = status_byte;
			REG_IDENTITY:  next_rdata = host_id;
			REG_ATTRIB:    next_rdata = attrib & ATTRIB_MASK;
			REG_IRQ_EN:    next_rdata = {5'h00, irq_en};
			REG_MSG_PORT:
			begin
				// Count first, then the packet; type is always zero, last byte reads zero
				if (rx_rd_idx == 3'h0)
					next_rdata = PKT_BYTE_COUNT;
				else if (rx_rd_idx == 3'h1)
					next_rdata = rx_mem[rx_rd_ptr][7:0];
				else if (rx_rd_idx == 3'h2)
					next_rdata = rx_mem[rx_rd_ptr][15:8];
				else
					next_rdata = 8'h00;
			end
			REG_ERR_PORT:
			begin
				if (err_rd_idx == 3'h0)
					next_rdata = PKT_BYTE_COUNT;
				else if (err_rd_idx <= 3'h4)
					next_rdata = err_byte[err_rd_idx[1:0] - 2'h1];
				else
					next_rdata = 8'h00;
			end
			default:       next_rdata = 8'h00;
		endcase
	end

	// Read data is captured during the wait cycle, stands through the completing edge
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			avs_readdata <= 32'h0000_0000;
		else if (avs_read & ~ack)
			avs_readdata <= {24'h00_0000, next_rdata};
	end

	// Setup state, identity and attributes; a soft reset returns to setup mode
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			setup_complete <= 1'b0;
			host_id        <= 8'h00;
			attrib         <= ATTRIB_RESET;
		end
		else if (soft_rst)
		begin
			setup_complete <= 1'b0;
			attrib         <= ATTRIB_RESET;
		end
		else if (acc_write & ~setup_complete)
		begin
			if (avs_address == REG_IDENTITY)
			begin
				host_id        <= wbyte;
				setup_complete <= 1'b1;
			end
			if (avs_address == REG_ATTRIB)
				attrib <= wbyte & ATTRIB_MASK;
		end
	end

	// Interrupt enables
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			irq_en <= 3'h0;
		else if (soft_rst)
			irq_en <= 3'h0;
		else if (acc_write & avs_address == REG_IRQ_EN)
			irq_en <= wbyte[2:0];
	end

	// Transmit buffer: one message, loaded byte by byte, armed by terminate write.
	// Bytes beyond the fourth are dropped; unwritten bytes keep their old value.
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			tx_wr_idx  <= 3'h0;
			tx_pending <= 1'b0;
			for (int i = 0; i < 4; i++)
				tx_byte[i] <= 8'h00;
		end
		else if (soft_rst)
		begin
			tx_wr_idx  <= 3'h0;
			tx_pending <= 1'b0;
		end
		else
		begin
			if (acc_write & avs_address == REG_MSG_PORT & ~tx_pending & tx_wr_idx < 3'h4)
			begin
				tx_byte[tx_wr_idx[1:0]] <= wbyte;
				tx_wr_idx               <= tx_wr_idx + 3'h1;
			end
			if (acc_write & avs_address == REG_TERMINATE & ~tx_pending)
			begin
				tx_pending <= 1'b1;
				tx_wr_idx  <= 3'h0;
			end
			else if (sbus_req_valid & sbus_result.done)
				tx_pending <= 1'b0;
		end
	end

	// Outgoing request is only offered once setup is complete
	assign sbus_req_valid = tx_pending & setup_complete;
	// Whole request in one assignment, so the struct has a single driver;
	// the upper request bytes carry no meaning and are sent as zero
	assign sbus_req = {
		{16'h0000, tx_byte[1], tx_byte[0]},
		{16'h0000, 8'h00, MSG_TYPE_INT},
		WIDTH_32,
		XFER_ONE};

	// Failure flag and error packet capture on a failed transfer
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			tx_failure_flag <= 1'b0;
			for (int i = 0; i < 4; i++)
				err_byte[i] <= 8'h00;
		end
		else if (soft_rst)
			tx_failure_flag <= 1'b0;
		else if (sbus_req_valid & sbus_result.done)
		begin
			tx_failure_flag <= sbus_result.retry_expired | sbus_result.bus_error
				| sbus_result.timeout;
			if (sbus_result.retry_expired | sbus_result.bus_error | sbus_result.timeout)
			begin
				err_byte[0] <= tx_byte[0];
				err_byte[1] <= tx_byte[1];
				err_byte[2] <= MSG_TYPE_INT;
				err_byte[3] <= (tx_byte[3] & REQ_ID_MASK)
					| ({7'h00, sbus_result.retry_expired} << ERR_RETRY_BIT)
					| ({7'h00, sbus_result.bus_error} << ERR_BUSERR_BIT)
					| ({7'h00, sbus_result.timeout} << ERR_TIMEOUT_BIT);
			end
		end
	end

	// Error port read position; a write to the port ends the retrieval
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			err_rd_idx <= 3'h0;
		else if (soft_rst)
			err_rd_idx <= 3'h0;
		else if (acc_write & avs_address == REG_ERR_PORT)
			err_rd_idx <= 3'h0;
		else if (acc_read & avs_address == REG_ERR_PORT & err_rd_idx < 3'h5)
			err_rd_idx <= err_rd_idx + 3'h1;
	end

	// Incoming filter: own identity, type zero, no bus error, room left
	assign sbus_in_accept = sbus_in.valid & setup_complete & ~soft_rst
		& sbus_in.dest == host_id
		& sbus_in.msg_type == MSG_TYPE_INT & ~sbus_in.bus_error
		& (rx_count < (PW+1)'(RX_DEPTH));
	assign rx_push = sbus_in_accept;
	assign rx_pop  = acc_read & avs_address == REG_TERMINATE & rx_fifo_has_msg;

	// Receive FIFO storage; the destination byte is the local identity by construction
	always_ff @(posedge mclk)
	begin
		if (rx_push)
			rx_mem[rx_wr_ptr] <= {sbus_in.source, sbus_in.dest};
	end

	// Receive pointers, count and read position
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			rx_wr_ptr <= '0;
			rx_rd_ptr <= '0;
			rx_count  <= '0;
			rx_rd_idx <= 3'h0;
		end
		else if (soft_rst)
		begin
			rx_wr_ptr <= '0;
			rx_rd_ptr <= '0;
			rx_count  <= '0;
			rx_rd_idx <= 3'h0;
		end
		else
		begin
			if (rx_push)
				rx_wr_ptr <= (rx_wr_ptr == PW'(RX_DEPTH - 1)) ? '0 : rx_wr_ptr + 1'b1;
			if (rx_pop)
				rx_rd_ptr <= (rx_rd_ptr == PW'(RX_DEPTH - 1)) ? '0 : rx_rd_ptr + 1'b1;
			if (rx_push & ~rx_pop)
				rx_count <= rx_count + 1'b1;
			else if (rx_pop & ~rx_push)
				rx_count <= rx_count - 1'b1;
			if (acc_read & avs_address == REG_TERMINATE)
				rx_rd_idx <= 3'h0;
			else if (acc_read & avs_address == REG_MSG_PORT & rx_rd_idx < 3'h5)
				rx_rd_idx <= rx_rd_idx + 3'h1;
		end
	end

	// End-of-interrupt blanking counter, started by an identity write after setup
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			eoi_cnt <= 4'h0;
		else if (acc_write & avs_address == REG_IDENTITY & setup_complete)
			eoi_cnt <= 4'(EOI_CYC);
		else if (eoi_cnt != 4'h0)
			eoi_cnt <= eoi_cnt - 4'h1;
	end
	assign irq_end_pulse = (eoi_cnt != 4'h0);

	// Interrupt output from a flop; enables cleared by soft reset drop it too.
	// The flop lags the counter by a cycle, so release one count early to keep
	// the blanking at EOI_CYC cycles rather than one more.
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			host_irq_out <= 1'b0;
		else if (soft_rst)
			host_irq_out <= 1'b0;
		else
			host_irq_out <= (eoi_cnt <= 4'h1)
				& ~(acc_write & avs_address == REG_IDENTITY & setup_complete)
				& ((irq_en[IE_TX_ROOM] & tx_fifo_has_room)
				| (irq_en[IE_RX_MSG] & rx_fifo_has_msg)
				| (irq_en[IE_TX_FAIL] & tx_failure_flag));
	end

endmodule

// >>> testbench/imh_host_port_assertions.sv
// Checker: timing and field relations at the host port boundary
`timescale 1ns/10ps
module imh_host_port_assertions
	import imh_pkg::*;
#(
	parameter int RX_DEPTH = 4
)(
	// Clock and reset
	input wire logic             mclk,
	input wire logic             resetn,
	// Register bus
	input wire logic [2:0]       avs_address,
	input wire logic             avs_read,
	input wire logic             avs_write,
	input wire logic [31:0]      avs_writedata,
	input wire logic [31:0]      avs_readdata,
	input wire logic             avs_waitrequest,
	// Interrupt
	input wire logic             host_irq_out,
	input wire logic             irq_end_pulse,
	// System bus
	input wire logic             sbus_req_valid,
	input wire imh_sbus_req_t    sbus_req,
	input wire imh_sbus_result_t sbus_result,
	input wire imh_sbus_in_t     sbus_in,
	input wire logic             sbus_in_accept
);
	logic wr_done;
	logic rd_done;
	logic term_wr;
	logic inited;
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	// Completing edges of bus accesses
	assign wr_done = avs_write && !avs_waitrequest;
	assign rd_done = avs_read && !avs_waitrequest;
	assign term_wr = wr_done && avs_address == REG_TERMINATE;
	// Shadow of setup state, built from bus traffic so a stuck design flag shows up
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			inited <= 1'b0;
		else if (wr_done && avs_address == REG_IDENTITY)
			inited <= 1'b1;
		else if (wr_done && avs_address == REG_STATUS)
			inited <= 1'b0;
	end
	width_one_xfer_a: assert property (
		sbus_req_valid |-> sbus_req.width == WIDTH_32 && sbus_req.xfers == XFER_ONE)
		else $error("bad width or transfer count");
	req_hold_a: assert property (
		sbus_req_valid && !sbus_result.done |=> sbus_req_valid && $stable(sbus_req))
		else $error("request dropped before done");
	reply_type_a: assert property (
		sbus_req_valid |-> sbus_req.reply_word[7:0] == MSG_TYPE_INT)
		else $error("reply type not zero");
	attrib_fixed_a: assert property (
		rd_done && avs_address == REG_ATTRIB |-> (avs_readdata & ~{24'h0, ATTRIB_MASK}) == 32'h0)
		else $error("fixed attribute bits set");
	unmapped_zero_a: assert property (
		rd_done && avs_address == 3'h6 |-> avs_readdata == 32'h0)
		else $error("unmapped read not zero");
	idle_before_setup_a: assert property (
		!inited |-> !sbus_req_valid && !sbus_in_accept)
		else $error("bus activity before setup");
	eoi_blank_a: assert property (
		inited && wr_done && avs_address == REG_IDENTITY |=> (!host_irq_out && irq_end_pulse) [*4])
		else $error("interrupt not blanked");
	soft_rst_quiet_a: assert property (
		wr_done && avs_address == REG_STATUS |=> !host_irq_out [*2])
		else $error("interrupt after soft reset");
	rst_waits_bus_a: assert property (
		avs_write && avs_address == REG_STATUS && sbus_req_valid |-> avs_waitrequest)
		else $error("soft reset during bus transfer");
	send_after_term_a: assert property (
		$rose(sbus_req_valid) |-> $past(term_wr))
		else $error("send without terminate write");
endmodule
bind imh_host_port imh_host_port_assertions #(.RX_DEPTH(RX_DEPTH)) chk (.mclk(mclk),
	.resetn(resetn), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .host_irq_out(host_irq_out),
	.irq_end_pulse(irq_end_pulse), .sbus_req_valid(sbus_req_valid), .sbus_req(sbus_req),
	.sbus_result(sbus_result), .sbus_in(sbus_in), .sbus_in_accept(sbus_in_accept));

// >>> testbench/imh_sbus_agent.sv
// Model of the system bus agents facing the message port
`timescale 1ns/10ps
module imh_sbus_agent
	import imh_pkg::*;
(
	// Clock and reset
	input wire logic         mclk,
	input wire logic         resetn,
	// Bench control: reply delay and failure flags
	input wire logic [7:0]   lat,
	input wire logic [2:0]   fail,
	// Outgoing and incoming messages
	input wire logic         sbus_req_valid,
	output imh_sbus_result_t sbus_result,
	output imh_sbus_in_t     sbus_in,
	input wire logic         sbus_in_accept
);
	logic [7:0] cnt;
	// Replier answers after lat cycles; flags carry junk outside done
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			cnt <= 8'h00;
			sbus_result <= 4'h7;
		end
		else if (sbus_req_valid && !sbus_result.done && cnt >= lat)
		begin
			cnt <= 8'h00;
			sbus_result <= {1'b1, fail};
		end
		else
		begin
			cnt <= sbus_req_valid ? cnt + 8'h01 : 8'h00;
			sbus_result <= {1'b0, ~fail};
		end
	end
	// One-cycle offer of a message; the lines are scrambled once released
	task automatic send(input logic [7:0] d, input logic [7:0] s, input logic [7:0] t,
		input logic be, output logic acc);
		@(posedge mclk);
		sbus_in <= {1'b1, d, s, t, be};
		@(posedge mclk);
		acc = sbus_in_accept;
		sbus_in <= {1'b0, ~d, ~s, ~t, ~be};
	endtask
	initial sbus_in = '0;
endmodule

// >>> testbench/imh_host_port_tb_top.sv
// Testbench: register-level tests of the message host port
`timescale 1ns/10ps
module imh_host_port_tb_top;
	import imh_pkg::*;
	logic             mclk = 1'b0;
	logic             resetn = 1'b0;
	logic [2:0]       avs_address = 3'h0;
	logic             avs_read = 1'b0;
	logic             avs_write = 1'b0;
	logic [31:0]      avs_writedata = 32'h0;
	logic [31:0]      avs_readdata;
	logic             avs_waitrequest;
	logic             host_irq_out;
	logic             irq_end_pulse;
	logic             sbus_req_valid;
	imh_sbus_req_t    sbus_req;
	imh_sbus_result_t sbus_result;
	imh_sbus_in_t     sbus_in;
	logic             sbus_in_accept;
	logic [7:0]       lat = 8'd20;
	logic [2:0]       fail = 3'h0;
	logic             acc;
	logic [31:0]      q;
	int               bad_count = 0;
	int               checked = 0;
	int               cycles = 0;
	logic [7:0]       ep [5] = '{8'h04, 8'h33, 8'h5A, 8'h00, 8'h59};
	logic [7:0]       rx [6] = '{8'h04, 8'h5A, 8'h21, 8'h00, 8'h00, 8'h00};
	imh_host_port dut (.mclk(mclk), .resetn(resetn), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.host_irq_out(host_irq_out), .irq_end_pulse(irq_end_pulse),
		.sbus_req_valid(sbus_req_valid), .sbus_req(sbus_req), .sbus_result(sbus_result),
		.sbus_in(sbus_in), .sbus_in_accept(sbus_in_accept));
	imh_sbus_agent far (.mclk(mclk), .resetn(resetn), .lat(lat), .fail(fail),
		.sbus_req_valid(sbus_req_valid), .sbus_result(sbus_result), .sbus_in(sbus_in),
		.sbus_in_accept(sbus_in_accept));
	// Clock, 50 ns period
	initial
	begin
		forever #25 mclk = ~mclk;
	end
	// Hang guard, well above the few hundred cycles the tests need
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			bad_count++;
			conclude();
		end
	end
	task automatic conclude();
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
			bad_count++;
		end
	endtask
	// Held until waitrequest is sampled low; one idle cycle between accesses
	task automatic bus(input logic wr, input logic [2:0] a, input logic [7:0] d);
		@(posedge mclk);
		avs_address <= a;
		avs_writedata <= {24'h0, d};
		avs_read <= !wr;
		avs_write <= wr;
		@(posedge mclk);
		while (avs_waitrequest)
			@(posedge mclk);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, input logic [31:0] exp);
		bus(1'b0, a, 8'h00);
		chk(q, exp);
	endtask
	// Four bytes then terminate: dest 33, source 5A, type 07 (overwritten), req id
	task automatic send_msg(input logic [7:0] id);
		bus(1'b1, REG_MSG_PORT, 8'h33);
		bus(1'b1, REG_MSG_PORT, 8'h5A);
		bus(1'b1, REG_MSG_PORT, 8'h07);
		bus(1'b1, REG_MSG_PORT, id);
		bus(1'b1, REG_TERMINATE, 8'h00);
	endtask
	initial
	begin
		repeat (8) @(posedge mclk);
		resetn <= 1'b1;
		rd(REG_STATUS, 32'h01);
		rd(3'h6, 32'h00);
		bus(1'b1, REG_ATTRIB, 8'hFF);
		rd(REG_ATTRIB, {24'h0, ATTRIB_MASK});
		rd(REG_IRQ_EN, 32'h00);
		far.send(8'h5A, 8'h21, 8'h00, 1'b0, acc);
		chk(acc, 32'h0);
		bus(1'b1, REG_IRQ_EN, 8'h07);
		bus(1'b1, REG_IDENTITY, 8'h5A);
		bus(1'b1, REG_ATTRIB, 8'h00);
		rd(REG_ATTRIB, 32'h70);
		rd(REG_IDENTITY, 32'h5A);
		rd(REG_STATUS, 32'h81);
		chk(host_irq_out, 32'h1);
		bus(1'b1, REG_IDENTITY, 8'h00);
		@(negedge mclk);
		chk(host_irq_out, 32'h0);
		repeat (3) @(negedge mclk);
		chk(host_irq_out, 32'h0);
		@(negedge mclk);
		chk(host_irq_out, 32'h1);
		$display("test setup done");
		send_msg(8'h09);
		rd(REG_STATUS, 32'h80);
		chk(sbus_req.req_word[15:0], 32'h5A33);
		while (!sbus_result.done)
			@(posedge mclk);
		rd(REG_STATUS, 32'h81);
		fail <= 3'b101;
		send_msg(8'h09);
		while (!sbus_result.done)
			@(posedge mclk);
		rd(REG_STATUS, 32'h85);
		foreach (ep[i]) rd(REG_ERR_PORT, {24'h0, ep[i]});
		bus(1'b1, REG_ERR_PORT, 8'h00);
		rd(REG_ERR_PORT, 32'h04);
		$display("test transmit done");
		far.send(8'h5A, 8'h21, 8'h00, 1'b0, acc);
		chk(acc, 32'h1);
		far.send(8'h5A, 8'h21, 8'h01, 1'b0, acc);
		chk(acc, 32'h0);
		far.send(8'h5A, 8'h21, 8'h00, 1'b1, acc);
		chk(acc, 32'h0);
		far.send(8'h3C, 8'h21, 8'h00, 1'b0, acc);
		chk(acc, 32'h0);
		far.send(8'h5A, 8'h47, 8'h00, 1'b0, acc);
		chk(acc, 32'h1);
		rd(REG_STATUS, 32'h87);
		foreach (rx[i]) rd(REG_MSG_PORT, {24'h0, rx[i]});
		bus(1'b0, REG_TERMINATE, 8'h00);
		rd(REG_STATUS, 32'h87);
		// Second queued message has its own source, so a stuck read pointer shows
		rx[2] = 8'h47;
		foreach (rx[i]) rd(REG_MSG_PORT, {24'h0, rx[i]});
		bus(1'b0, REG_TERMINATE, 8'h00);
		rd(REG_STATUS, 32'h85);
		$display("test receive done");
		lat <= 8'd30;
		fail <= 3'b010;
		send_msg(8'h02);
		bus(1'b1, REG_STATUS, 8'h00);
		chk(sbus_req_valid, 32'h0);
		rd(REG_STATUS, 32'h01);
		rd(REG_IRQ_EN, 32'h00);
		chk(host_irq_out, 32'h0);
		$display("test soft reset done");
		conclude();
	end
endmodule
